// ---- shared/cps_cfg.svh ----
// Purpose: Constants of the charger protection supervisor.
// Assumes: Times are whole microseconds, clock period in nanoseconds.
// Notes:   Cycle counts are derived from the times and the clock period.
`ifndef CPS_CFG_SVH
`define CPS_CFG_SVH

// ==================================================================
// Clock and timing
`define CPS_CLK_PERIOD_NS   10
`define CPS_HICCUP_OFF_US   30000
`define CPS_HICCUP_ON_US    250
`define CPS_IRQ_US          256
`define CPS_SHIP_DEGLITCH_US 1000
`define CPS_US_TO_CYC(us)   (((us) * 1000) / `CPS_CLK_PERIOD_NS)
`define CPS_CNT_W           32

// ==================================================================
// Register map, byte addresses on the APB
`define CPS_APB_AW          8
`define CPS_ADDR_CTRL       8'h00
`define CPS_ADDR_FAULT      8'h04
`define CPS_ADDR_STATUS     8'h08

// ==================================================================
// Reset values and fault codes
`define CPS_CTRL_RESET      13'h0000
`define CPS_CODE_NONE       2'h0
`define CPS_CODE_INPUT_OVP  2'h1
`define CPS_CODE_THERM_SHUT 2'h2

`endif

// ---- shared/cps_pkg.sv ----
// Purpose: Types of the charger protection supervisor.
// Assumes: Field order inside each struct is the register bit layout, MSB first.
// Notes:   Constants live in cps_cfg.svh.
`default_nettype none

package cps_pkg;

    // ==================================================================
    // Comparator and sensor flags from the analog stage
    typedef struct packed {
        logic inputOvp;      // Input above selected over-voltage threshold.
        logic system_overvoltage_event;        // System above minimum system voltage plus margin.
        logic boostOcp;      // Boost output over-current.
        logic boostOvp;      // Boost output over-voltage.
        logic thermHot;      // Die above selected regulation temperature.
        logic thermShut;     // Die above shutdown temperature.
        logic thermCool;     // Die below shutdown temperature minus hysteresis.
        logic battery_overvoltage_event;        // Battery above regulation setting plus margin.
        logic batDepleted;   // Battery below depletion level.
        logic batShort;      // Battery below short threshold.
        logic batOcp;        // Battery discharge over-current.
        logic inputPresent;  // Input source detected.
        logic quickOnN;      // Quick-on pin, active low.
    } cps_sense_type;

    // ==================================================================
    // Controls to the power stage
    typedef struct packed {
        logic switchStop;
        logic sysSink;
        logic revBlockOn;
        logic batSwitchOn;
        logic chargeStop;
        logic currentReduce;
        logic timerHalfRate;
        logic termDisable;
        logic shortCharge;
    } cps_power_type;

    // ==================================================================
    // Register layouts
    typedef struct packed {
        logic [2:0] minSystemVoltage;
        logic [3:0] prechargeCurrentSel;
        logic [1:0] thermRegSel;
        logic       boostEnable;
        logic [2:0] inputOvpThresholdSel;
    } cps_ctrl_type;

    typedef struct packed {
        logic       batteryOvpFlag;
        logic       boostFault;
        logic [1:0] chargeFaultCode;
    } cps_fault_type;

    typedef struct packed {
        logic thermShutdown;
        logic ocpLatched;
        logic depletionLatched;
        logic hiccupActive;
        logic batSwitchOn;
        logic thermalRegulationFlag;
    } cps_status_type;

    typedef enum logic [1:0] {HIC_IDLE, HIC_OFF, HIC_ON} cps_hic_type;
    typedef enum logic [1:0] {SEL_CTRL, SEL_FAULT, SEL_STATUS, SEL_NONE} cps_sel_type;

    // ==================================================================
    // Whole state of the supervisor
    typedef struct packed {
        cps_sense_type  senPrev;
        cps_ctrl_type   ctrl;
        cps_fault_type  fault;
        logic [2:0]     actPrev;
        logic           readSeen;
        logic           irqArmed;
        logic           irqN;
        logic [31:0]    irqCnt;
        cps_hic_type    hic;
        logic [31:0]    hicCnt;
        logic           thermShutL;
        logic           deplL;
        logic           ocpL;
        logic [31:0]    qonCnt;
        logic           qonDone;
        cps_power_type  power;
        logic           pready;
        logic           pslverr;
        logic [31:0]    prdata;
    } cps_state_type;

endpackage : cps_pkg

`default_nettype wire

// ---- design/cps_sync.sv ----
// Purpose: Three-stage synchroniser for a vector of asynchronous flags.
// Assumes: Inputs may change at any time relative to mclk.
// Notes:   A value is accepted only when the second and third stages agree.
`timescale 1ns/1ns
`default_nettype none

module cps_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         reset_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] rawIn,
    output var  logic [W-1:0] syncOut
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] v;
    } cps_sync_state_type;

    cps_sync_state_type s_q;
    cps_sync_state_type s_d;

    // ==================================================================
    // Stage chain with agreement filter
    always_comb begin
        s_d    = s_q;
        s_d.s1 = rawIn;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        for (int i = 0; i < W; i++) begin
            if (s_q.s2[i] == s_q.s3[i]) begin
                s_d.v[i] = s_q.s3[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign syncOut = s_q.v;

endmodule : cps_sync

`default_nettype wire

// ---- design/cps_supervisor.sv ----
// Purpose: Fault supervisor of a single-cell charger with reverse boost.
// Assumes: Analog comparators compare against the selects driven here.
// Notes:   Registers are reached over APB; all outputs come from flops.
`timescale 1ns/1ns
`default_nettype none
`include "cps_cfg.svh"

module cps_supervisor
    import cps_pkg::*;
#(
    parameter int unsigned HICCUP_OFF_CYC = `CPS_US_TO_CYC(`CPS_HICCUP_OFF_US),
    parameter int unsigned HICCUP_ON_CYC  = `CPS_US_TO_CYC(`CPS_HICCUP_ON_US),
    parameter int unsigned IRQ_CYC        = `CPS_US_TO_CYC(`CPS_IRQ_US),
    parameter int unsigned SHIP_CYC       = `CPS_US_TO_CYC(`CPS_SHIP_DEGLITCH_US)
) (
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic                   ce,
    input  wire cps_sense_type          senseIn,
    output var  cps_power_type          power,
    output var  logic [2:0]             inputOvpThresholdSel,
    output var  logic [1:0]             thermRegSel,
    output var  logic [3:0]             prechargeCurrentSel,
    output var  logic [2:0]             minSystemVoltage,
    output var  logic                   host_irq_n,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`CPS_APB_AW-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output var  logic                   pready,
    output var  logic                   pslverr,
    output var  logic [31:0]            prdata
);

    localparam logic [31:0] OFF_LAST  = 32'(HICCUP_OFF_CYC - 1);
    localparam logic [31:0] ON_LAST   = 32'(HICCUP_ON_CYC - 1);
    localparam logic [31:0] IRQ_LAST  = 32'(IRQ_CYC - 1);
    localparam logic [31:0] SHIP_LAST = 32'(SHIP_CYC - 1);

    cps_state_type s_q;
    cps_state_type s_d;
    cps_sense_type sen;
    logic [$bits(cps_sense_type)-1:0] senVec;

    // ==================================================================
    // Input synchronisation
    cps_sync #(
        .W($bits(cps_sense_type))
    ) u_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .ce      (ce),
        .rawIn   (senseIn),
        .syncOut (senVec)
    );

    assign sen = cps_sense_type'(senVec);

    // ==================================================================
    // Address decode, shared by writes and reads
    function automatic cps_sel_type decodeAddr(input logic [`CPS_APB_AW-1:0] a);
        case (a)
            `CPS_ADDR_CTRL:   decodeAddr = SEL_CTRL;
            `CPS_ADDR_FAULT:  decodeAddr = SEL_FAULT;
            `CPS_ADDR_STATUS: decodeAddr = SEL_STATUS;
            default:          decodeAddr = SEL_NONE;
        endcase
    endfunction : decodeAddr

    // ==================================================================
    // Next-state logic
    logic           buck;
    logic           boost;
    logic           access;
    logic           rdFault;
    logic           shipExit;
    logic           trig;
    logic [2:0]     actNow;
    cps_fault_type  act;
    cps_fault_type  base;
    cps_status_type stat;

    always_comb begin
        s_d      = s_q;
        boost    = s_q.ctrl.boostEnable;
        buck     = !boost;
        access   = psel && penable && !s_q.pready;
        rdFault  = access && !pwrite && (decodeAddr(paddr) == SEL_FAULT);
        shipExit = !sen.quickOnN && !s_q.qonDone && (s_q.qonCnt == SHIP_LAST);
        s_d.senPrev = sen;

        // Latched battery switch conditions.
        if (sen.thermShut) begin
            s_d.thermShutL = 1'b1;
        end else if (sen.thermCool) begin
            s_d.thermShutL = 1'b0;
        end
        if (sen.batDepleted) begin
            s_d.deplL = 1'b1;
        end else if (sen.inputPresent) begin
            s_d.deplL = 1'b0;
        end
        if (sen.quickOnN) begin
            s_d.qonCnt  = '0;
            s_d.qonDone = 1'b0;
        end else if (!s_q.qonDone) begin
            if (shipExit) begin
                s_d.qonDone = 1'b1;
            end else begin
                s_d.qonCnt = s_q.qonCnt + 32'h0000_0001;
            end
        end
        if (sen.batOcp) begin
            s_d.ocpL = 1'b1;
        end else if (shipExit) begin
            s_d.ocpL = 1'b0;
        end

        // Boost over-current hiccup.
        case (s_q.hic)
            HIC_IDLE: begin
                s_d.hicCnt = '0;
                if (sen.boostOcp) begin
                    s_d.hic = HIC_OFF;
                end
            end
            HIC_OFF: begin
                if (s_q.hicCnt == OFF_LAST) begin
                    s_d.hic    = HIC_ON;
                    s_d.hicCnt = '0;
                end else begin
                    s_d.hicCnt = s_q.hicCnt + 32'h0000_0001;
                end
            end
            HIC_ON: begin
                if (s_q.hicCnt == ON_LAST) begin
                    s_d.hic    = sen.boostOcp ? HIC_OFF : HIC_IDLE;
                    s_d.hicCnt = '0;
                end else begin
                    s_d.hicCnt = s_q.hicCnt + 32'h0000_0001;
                end
            end
            default: begin
                s_d.hic = HIC_IDLE;
            end
        endcase
        if (buck) begin
            s_d.hic = HIC_IDLE;
        end

        // Fault recording; a read empties the history, new faults still land.
        act.chargeFaultCode = (buck && sen.thermShut) ? `CPS_CODE_THERM_SHUT :
                              (buck && sen.inputOvp)  ? `CPS_CODE_INPUT_OVP  :
                                                        `CPS_CODE_NONE;
        act.boostFault      = boost && (sen.boostOcp || sen.boostOvp);
        act.batteryOvpFlag  = sen.battery_overvoltage_event;
        actNow = {act.chargeFaultCode != `CPS_CODE_NONE, act.boostFault,
                  act.batteryOvpFlag};
        base = rdFault ? '0 : s_q.fault;
        s_d.fault.boostFault     = base.boostFault || act.boostFault;
        s_d.fault.batteryOvpFlag = base.batteryOvpFlag || act.batteryOvpFlag;
        s_d.fault.chargeFaultCode = (base.chargeFaultCode != `CPS_CODE_NONE) ?
                                    base.chargeFaultCode : act.chargeFaultCode;
        s_d.actPrev = actNow;
        trig = |(actNow & ~s_q.actPrev);

        // Interrupt pulse, re-armed once the faults are gone after a fault register read.
        if (rdFault) begin
            s_d.readSeen = 1'b1;
        end
        if (!s_q.irqArmed && s_q.readSeen && actNow == 3'h0) begin
            s_d.irqArmed = 1'b1;
            s_d.readSeen = 1'b0;
        end
        if (trig && s_q.irqArmed) begin
            s_d.irqArmed = 1'b0;
            s_d.readSeen = 1'b0;
            s_d.irqN     = 1'b0;
            s_d.irqCnt   = IRQ_LAST;
        end else if (!s_q.irqN) begin
            if (s_q.irqCnt == 32'h0000_0000) begin
                s_d.irqN = 1'b1;
            end else begin
                s_d.irqCnt = s_q.irqCnt - 32'h0000_0001;
            end
        end

        // APB slave, answering one cycle into the access phase.
        s_d.pready  = access;
        s_d.pslverr = 1'b0;
        if (access) begin
            s_d.pslverr = (decodeAddr(paddr) == SEL_NONE);
            s_d.prdata  = 32'h0000_0000;
            if (pwrite) begin
                if (decodeAddr(paddr) == SEL_CTRL) begin
                    s_d.ctrl = cps_ctrl_type'(pwdata[$bits(cps_ctrl_type)-1:0]);
                end
            end else begin
                case (decodeAddr(paddr))
                    SEL_CTRL:   s_d.prdata = 32'(s_q.ctrl);
                    SEL_FAULT:  s_d.prdata = 32'(s_q.fault);
                    SEL_STATUS: s_d.prdata = 32'(stat);
                    default:    s_d.prdata = 32'h0000_0000;
                endcase
            end
        end
        // Hardware leaving boost wins over a write in the same cycle.
        if (boost && (sen.boostOvp || sen.thermShut)) begin
            s_d.ctrl.boostEnable = 1'b0;
        end

        // Power stage controls.
        s_d.power.switchStop    = (buck && (sen.inputOvp || sen.system_overvoltage_event
                                  || s_d.thermShutL))
                                  || (boost && sen.boostOvp);
        s_d.power.sysSink       = buck && sen.system_overvoltage_event;
        s_d.power.revBlockOn    = !(boost && s_d.hic == HIC_OFF);
        s_d.power.batSwitchOn   = !(s_d.thermShutL || s_d.deplL || s_d.ocpL);
        s_d.power.chargeStop    = s_d.power.switchStop || sen.battery_overvoltage_event || boost;
        s_d.power.currentReduce = buck && sen.thermHot;
        s_d.power.timerHalfRate = buck && sen.thermHot;
        s_d.power.termDisable   = buck && sen.thermHot;
        s_d.power.shortCharge   = s_d.power.batSwitchOn && sen.batShort;
    end

    always_comb begin
        stat.thermShutdown         = s_q.thermShutL;
        stat.ocpLatched            = s_q.ocpL;
        stat.depletionLatched      = s_q.deplL;
        stat.hiccupActive          = (s_q.hic != HIC_IDLE);
        stat.batSwitchOn           = s_q.power.batSwitchOn;
        stat.thermalRegulationFlag = s_q.power.currentReduce;
    end

    // ==================================================================
    // State register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_q                  <= '0;
            s_q.ctrl             <= `CPS_CTRL_RESET;
            s_q.irqArmed         <= 1'b1;
            s_q.irqN             <= 1'b1;
            s_q.qonDone          <= 1'b1;
            s_q.hic              <= HIC_IDLE;
            s_q.power.revBlockOn <= 1'b1;
            s_q.power.batSwitchOn <= 1'b1;
            s_q.power.chargeStop <= 1'b1;
            s_q.senPrev.quickOnN <= 1'b1;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ==================================================================
    // Outputs
    assign power                = s_q.power;
    assign inputOvpThresholdSel = s_q.ctrl.inputOvpThresholdSel;
    assign thermRegSel          = s_q.ctrl.thermRegSel;
    assign prechargeCurrentSel  = s_q.ctrl.prechargeCurrentSel;
    assign minSystemVoltage     = s_q.ctrl.minSystemVoltage;
    assign host_irq_n           = s_q.irqN;
    assign pready               = s_q.pready;
    assign pslverr              = s_q.pslverr;
    assign prdata               = s_q.prdata;

    // ==================================================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n || !ce);

    logic [31:0] lowCnt;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lowCnt <= '0;
        end else if (ce) begin
            lowCnt <= s_q.irqN ? 32'h0000_0000 : lowCnt + 32'h0000_0001;
        end
    end

    sequence hicEnter;
        s_q.hic == HIC_IDLE && s_q.ctrl.boostEnable && sen.boostOcp ##1 s_q.hic == HIC_OFF;
    endsequence
    sequence hicOnEnd;
        s_q.hic == HIC_ON && s_q.hicCnt == ON_LAST && s_q.ctrl.boostEnable;
    endsequence

    input_ovp_stop_a: assert property (!s_q.ctrl.boostEnable && sen.inputOvp
        |=> power.switchStop) else $error("input over-voltage did not stop switching");
    input_ovp_code_a: assert property (!s_q.ctrl.boostEnable && sen.inputOvp
        && !sen.thermShut |=> s_q.fault.chargeFaultCode != `CPS_CODE_NONE)
        else $error("input over-voltage code not recorded");
    sys_sink_on_a: assert property (!s_q.ctrl.boostEnable && sen.system_overvoltage_event
        |=> power.sysSink && power.switchStop) else $error("system sink not enabled");
    hiccup_off_a: assert property (hicEnter |-> !power.revBlockOn)
        else $error("reverse switch on during hiccup off");
    hiccup_exit_a: assert property (hicOnEnd ##0 !sen.boostOcp
        |=> s_q.hic == HIC_IDLE) else $error("hiccup did not end");
    boost_ovp_exit_a: assert property (s_q.ctrl.boostEnable && sen.boostOvp
        |=> !s_q.ctrl.boostEnable && s_q.fault.boostFault && power.switchStop)
        else $error("boost not left");
    therm_reg_a: assert property (!s_q.ctrl.boostEnable && sen.thermHot
        |=> power.currentReduce && power.timerHalfRate && power.termDisable)
        else $error("thermal regulation effects missing");
    therm_shut_off_a: assert property (sen.thermShut |=> !power.batSwitchOn)
        else $error("battery switch on in thermal shutdown");
    irq_pulse_len_a: assert property ($rose(s_q.irqN) |-> lowCnt == IRQ_LAST + 1)
        else $error("interrupt pulse length wrong");
    irq_once_a: assert property ($fell(s_q.irqN) |-> !s_q.irqArmed)
        else $error("interrupt left armed after pulse");

endmodule : cps_supervisor

`default_nettype wire

// ---- dv/cps_stage_model.sv ----
// Purpose: Analog power stage stand-in driving the supervisor's sense flags.
// Assumes: Flags change just after a rising edge of mclk.
// Notes:   Quick-on idles high, as its pull-up would hold it.
`timescale 1ns/1ns
`default_nettype none
module cps_stage_model
    import cps_pkg::*;
(
    input  wire logic          mclk,
    output var  cps_sense_type senseIn
);
    // ==================================================================
    // Stimulus tasks
    initial senseIn = 13'h0001;
    task automatic apply(input cps_sense_type f);
        @(posedge mclk);
        senseIn <= f;
    endtask : apply
    task automatic ship_exit(input int lowCyc);
        @(posedge mclk);
        senseIn.quickOnN <= 1'b0;
        repeat (lowCyc) @(posedge mclk);
        senseIn.quickOnN <= 1'b1;
    endtask : ship_exit
endmodule : cps_stage_model
`default_nettype wire

// ---- dv/testbench.sv ----
// Purpose: Self-checking bench of the charger protection supervisor.
// Assumes: Shortened timing parameters; expectations follow the fault rules.
// Notes:   Registers are reached by an APB master with bounded waits.
`timescale 1ns/1ns
`default_nettype none
module testbench
    import cps_pkg::*;
;
    localparam int IRQ = 8, OFF = 40, ON = 10, SHIP = 16;
    logic          mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic          err;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0000_0000, rd, lfsr = 32'h0000_cd59;
    wire           pready, pslverr, host_irq_n;
    wire  [31:0]   prdata;
    wire  [11:0]   sel;
    wire cps_power_type power;
    cps_sense_type sense;
    int            miscompares = 0, check_count = 0, w;
    always #5 mclk = ~mclk;
    cps_stage_model cps_stage_model_inst (.mclk(mclk), .senseIn(sense));
    cps_supervisor #(.HICCUP_OFF_CYC(OFF), .HICCUP_ON_CYC(ON), .IRQ_CYC(IRQ), .SHIP_CYC(SHIP))
    cps_supervisor_inst (.mclk(mclk), .reset_n(reset_n), .ce(1'b1), .senseIn(sense),
        .power(power), .inputOvpThresholdSel(sel[2:0]), .thermRegSel(sel[4:3]),
        .prechargeCurrentSel(sel[8:5]), .minSystemVoltage(sel[11:9]),
        .host_irq_n(host_irq_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));
    // ==================================================================
    // Shared tasks
    function automatic logic [31:0] next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : next
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic bound(input int n);
        if (n >= 200) begin
            miscompares++;
            report_and_stop();
        end
    endtask : bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 200);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        bound(n);
    endtask : apb
    task automatic rdf(input logic [31:0] exp);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk(rd, exp);
    endtask : rdf
    task automatic go(input logic [12:0] f);
        cps_stage_model_inst.apply(f);
        repeat (8) @(posedge mclk);
    endtask : go
    function automatic logic pick(input int s);
        return s == 0 ? host_irq_n : power.revBlockOn;
    endfunction : pick
    task automatic width(input int s, input logic lvl);
        int n;
        n = 0;
        w = 0;
        while (pick(s) !== lvl && n < 200) begin
            @(posedge mclk);
            n++;
        end
        while (pick(s) === lvl && w < 200) begin
            @(posedge mclk);
            w++;
        end
        bound(n + w);
    endtask : width
    // ==================================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        chk(32'(power), 32'h0000_0070);
        for (int i = 0; i < 4; i++) begin
            lfsr = next(lfsr);
            apb(1'b1, 8'h00, {19'h0, lfsr[12:6], i[1:0], 1'b0, lfsr[2:0]});
            apb(1'b0, 8'h00, 32'h0000_0000);
            chk(rd, {19'h0, lfsr[12:6], i[1:0], 1'b0, lfsr[2:0]});
            chk(32'(sel), {20'h0, lfsr[12:6], i[1:0], lfsr[2:0]});
        end
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk({rd[30:0], err}, 32'h0000_0001);
        $display("Test registers done");
        cps_stage_model_inst.apply(13'h1001);
        width(0, 1'b0);
        chk(w, IRQ);
        chk(power.switchStop, 1'b1);
        rdf(32'h0000_0001);
        go(13'h0001);
        chk(power.switchStop, 1'b0);
        rdf(32'h0000_0001);
        rdf(32'h0000_0000);
        cps_stage_model_inst.apply(13'h08A1);
        width(0, 1'b0);
        chk(w, IRQ);
        go(13'h08A1);
        chk(host_irq_n, 1'b1);
        chk({power.switchStop, power.sysSink, power.batSwitchOn}, 3'b110);
        rdf(32'h0000_000A);
        go(13'h0041);
        chk(power.batSwitchOn, 1'b1);
        rdf(32'h0000_000A);
        rdf(32'h0000_0000);
        go(13'h0101);
        chk({power.currentReduce, power.timerHalfRate, power.termDisable}, 3'b111);
        go(13'h0021);
        rdf(32'h0000_0008);
        go(13'h0001);
        rdf(32'h0000_0008);
        rdf(32'h0000_0000);
        $display("Test buck faults done");
        apb(1'b1, 8'h00, 32'h0000_0008);
        cps_stage_model_inst.apply(13'h0401);
        width(1, 1'b0);
        chk(w, OFF);
        width(1, 1'b1);
        chk(w, ON);
        go(13'h0001);
        repeat (60) @(posedge mclk);
        chk(power.revBlockOn, 1'b1);
        rdf(32'h0000_0004);
        rdf(32'h0000_0000);
        go(13'h0201);
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk({rd[3], power.switchStop}, 2'b00);
        go(13'h0001);
        apb(1'b1, 8'h00, 32'h0000_0008);
        go(13'h0081);
        chk(power.batSwitchOn, 1'b0);
        go(13'h0041);
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk({rd[3], power.batSwitchOn}, 2'b01);
        $display("Test boost faults done");
        go(13'h0011);
        go(13'h0001);
        chk(power.batSwitchOn, 1'b0);
        go(13'h000B);
        chk({power.batSwitchOn, power.shortCharge}, 2'b11);
        go(13'h0005);
        go(13'h0003);
        chk(power.batSwitchOn, 1'b0);
        cps_stage_model_inst.ship_exit(SHIP + 4);
        repeat (8) @(posedge mclk);
        chk(power.batSwitchOn, 1'b1);
        $display("Test battery faults done");
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
